// ==== hw/sfw_pkg.sv ====
// Shared constants and types for the serial flash wrap/enhance/erase link.
// Assumes one 200 MHz reference clock on both ends of the link.
package sfw_pkg;
	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_WR_ENABLE        = 8'h06;
	localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
	localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE      = 8'hD8;
	localparam logic [7:0] OP_SET_BURST        = 8'hC0;
	localparam logic [7:0] OP_QUAD_IO_READ     = 8'hEB;
	localparam logic [7:0] OP_MODE_EXIT        = 8'hFF;
	// ==========================================================
	// Frame positions, counted in received bits
	localparam logic [3:0] WRAP_OFF_NIB  = 4'h1;
	localparam logic [7:0] WRAP_MAX_CODE = 8'h03;
	localparam logic [6:0] NB_CMD        = 7'h08;
	localparam logic [6:0] NB_BURST      = 7'h10;
	localparam logic [6:0] NB_ERASE      = 7'h20;
	localparam logic [6:0] NB_MODE       = 7'h28;
	localparam logic [6:0] NB_CAP        = 7'h78;
	localparam int unsigned DUMMY_CLKS   = 4;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_MHZ                  = 200;
	localparam int unsigned SECTOR_ERASE_TIME_US     = 50;
	localparam int unsigned HALF_BLOCK_ERASE_TIME_US = 100;
	localparam int unsigned BLOCK_ERASE_TIME_US      = 200;
	localparam int unsigned SECTOR_ERASE_CYC     = SECTOR_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned HALF_BLOCK_ERASE_CYC = HALF_BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned BLOCK_ERASE_CYC      = BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned SCLK_HALF_CYC        = 8;
	// ==========================================================
	// Erase alignment
	localparam logic [23:0] SECTOR_MASK     = 24'h00_0FFF;
	localparam logic [23:0] HALF_BLOCK_MASK = 24'h00_7FFF;
	localparam logic [23:0] BLOCK_MASK      = 24'h00_FFFF;
	// ==========================================================
	// Controller register map
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_ADDR      = 8'h04;
	localparam logic [7:0] REG_ARG       = 8'h08;
	localparam logic [7:0] REG_STATUS    = 8'h0C;
	localparam logic [7:0] REG_RDATA     = 8'h10;
	localparam int unsigned CTRL_GO_BIT   = 8;
	localparam int unsigned CTRL_QUAD_BIT = 9;
	localparam int unsigned CTRL_SKIP_BIT = 10;
	localparam logic [1:0] RESP_OKAY     = 2'b00;
	localparam logic [1:0] RESP_SLVERR   = 2'b10;
	typedef enum logic [1:0] {ER_SECTOR, ER_HALF_BLOCK, ER_BLOCK} sfw_erase_t;
endpackage

// ==== hw/sfw_link_if.sv ====
// Four-lane serial flash link between controller and flash.
// Assumes undriven lanes are pulled up to one.
`timescale 1ns/1ps
interface sfw_link_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] host_dq;
	logic [3:0] host_oe;
	logic [3:0] dev_dq;
	logic [3:0] dev_oe;
	logic [3:0] dq;
	// ==========================================================
	// Wire resolution, pull-up when nobody drives
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dq[i] = dev_oe[i] ? dev_dq[i] : (host_oe[i] ? host_dq[i] : 1'b1);
		end
	end
	modport host (output cs_n, output sclk, output host_dq, output host_oe, input dq);
	modport dev (input cs_n, input sclk, input dq, output dev_dq, output dev_oe);
endinterface

// ==== hw/sfw_dev.sv ====
// Flash-side command logic: burst wrap, continuous quad read, erases.
// Assumes the link pins are asynchronous; memory array sits outside.
`timescale 1ns/1ps
// Summary of operation
// - Reset leaves wrapping switched off
// - Wrapped reads stay inside aligned window
// - Host sends burst opcode then wrap code
// - Codes 00h-03h give 8-64 byte wraps
// - Code 1xh switches wrapping off
// - Setting holds until reset, resend replaces
// - Wrapping applies only to quad io read
// - Opcode in 8 single or 2 quad clocks
// - Toggling indicator enters continuous read mode
// - Non-toggling indicator leaves mode next frame
// - Continuous mode frames start with address
// - Continuous mode only with quad io read
// - Host exits mode with all-ones pattern
// - Host sends indicator then dummy clocks
// - Sector erase clears 4K sector
// - Erase needs write enable latch set
// - Erase rejected unless byte-exact select rise
// - Host sends opcode, three address bytes
// - Erase starts at select rise, busy flag
// - Protected regions are never erased
// - Half block erase uses address bit 15 up
// - Block erase clears containing 64K block
// - Quad reads need quad enable set
module sfw_dev #(
	parameter int unsigned SE_CYC = sfw_pkg::SECTOR_ERASE_CYC,
	parameter int unsigned HB_CYC = sfw_pkg::HALF_BLOCK_ERASE_CYC,
	parameter int unsigned BE_CYC = sfw_pkg::BLOCK_ERASE_CYC,
	parameter int unsigned DUMMY  = sfw_pkg::DUMMY_CLKS
) (
	input  wire logic                i_ref_clk,
	input  wire logic                i_rst,
	sfw_link_if.dev                  link,
	input  wire logic                i_quad_cmd_mode,
	input  wire logic                i_quad_enable,
	input  wire logic                i_protect_mode_select,
	input  wire logic [3:0]          i_block_protect_bits,
	input  wire logic [15:0]         i_sector_protect_bits,
	input  wire logic [7:0]          i_rd_data,
	output logic [23:0]              o_rd_addr,
	output logic                     o_write_in_progress,
	output logic                     o_write_enable_latch,
	output logic                     o_wrap_enable,
	output logic [1:0]               o_wrap_depth,
	output logic                     o_cont_read,
	output logic                     o_erase_start,
	output sfw_pkg::sfw_erase_t      o_erase_kind,
	output logic [23:0]              o_erase_addr
);
	import sfw_pkg::*;

	typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_DUMMY, PH_DATA, PH_DROP} sfw_dph_t;

	typedef struct packed {
		logic [1:0]  sclk_s;
		logic        sclk_q;
		logic [1:0]  cs_s;
		logic        cs_q;
		logic [3:0]  dq_s0;
		logic [3:0]  dq_s1;
		sfw_dph_t    ph;
		logic [7:0]  cmd;
		logic [31:0] sh;
		logic [6:0]  nbits;
		logic        all_ones;
		logic [23:0] addr;
		logic [3:0]  dcnt;
		logic        hi;
		logic [7:0]  obyte;
		logic [3:0]  dq_o;
		logic        dq_oe;
		logic        cont;
		logic        wrap_en;
		logic [1:0]  depth;
		logic        write_enable_latch;
		logic        write_in_progress;
		logic [31:0] tmr;
		logic        er_start;
		sfw_erase_t  er_kind;
		logic [23:0] er_addr;
	} sfw_dev_st_t;

	sfw_dev_st_t s;
	sfw_dev_st_t next_s;

	// ==========================================================
	// Helpers
	function automatic logic [23:0] step_addr(input logic [23:0] a, input logic en,
	                                          input logic [1:0] d);
		logic [23:0] m;
		m = (24'h00_0008 << d) - 24'h00_0001;
		return en ? ((a & ~m) | ((a + 24'h00_0001) & m)) : a + 24'h00_0001;
	endfunction

	function automatic logic is_prot(input logic [23:0] a, input logic sel,
	                                 input logic [3:0] bp, input logic [15:0] sector_protect_bits);
		logic [4:0] lim;
		lim = 5'h10 - {1'b0, bp};
		return sel ? sector_protect_bits[a[23:20]] : (bp != 4'h0 && {1'b0, a[23:20]} >= lim);
	endfunction

	function automatic logic is_erase(input logic [7:0] op);
		return op == OP_SECTOR_ERASE || op == OP_HALF_BLOCK_ERASE || op == OP_BLOCK_ERASE;
	endfunction

	// ==========================================================
	// Link edge detection on synchronised pins
	logic        rise;
	logic        fall;
	logic        cs_fall;
	logic        cs_rise;
	logic        quadw;
	logic [31:0] rx_sh;
	logic [6:0]  rx_nb;
	logic        rx_ones;

	assign rise    = s.sclk_s[1] & ~s.sclk_q & ~s.cs_s[1];
	assign fall    = ~s.sclk_s[1] & s.sclk_q & ~s.cs_s[1];
	assign cs_fall = ~s.cs_s[1] & s.cs_q;
	assign cs_rise = s.cs_s[1] & ~s.cs_q;
	// Upper lanes are ignored while a single-lane opcode is entered
	assign quadw   = i_quad_cmd_mode | (s.cmd == OP_QUAD_IO_READ && s.nbits >= NB_CMD);
	assign rx_sh   = quadw ? {s.sh[27:0], s.dq_s1} : {s.sh[30:0], s.dq_s1[0]};
	assign rx_nb   = (s.nbits >= NB_CAP) ? s.nbits : s.nbits + (quadw ? 7'h04 : 7'h01);
	assign rx_ones = quadw ? &s.dq_s1 : s.dq_s1[0];

	// ==========================================================
	// Next state
	always_comb begin
		next_s          = s;
		next_s.sclk_s   = {s.sclk_s[0], link.sclk};
		next_s.cs_s     = {s.cs_s[0], link.cs_n};
		next_s.dq_s0    = link.dq;
		next_s.dq_s1    = s.dq_s0;
		next_s.sclk_q   = s.sclk_s[1];
		next_s.cs_q     = s.cs_s[1];
		next_s.er_start = 1'b0;
		if (s.write_in_progress) begin
			if (s.tmr == 32'h0000_0000) begin
				next_s.write_in_progress = 1'b0;
				next_s.write_enable_latch = 1'b0;
			end else begin
				next_s.tmr = s.tmr - 32'h0000_0001;
			end
		end
		if (cs_fall) begin
			next_s.all_ones = 1'b1;
			next_s.sh       = 32'h0000_0000;
			next_s.dq_oe    = 1'b0;
			if (s.cont) begin
				// Frame opens straight with the address
				next_s.nbits = NB_CMD;
				next_s.cmd   = OP_QUAD_IO_READ;
				next_s.ph    = (!i_quad_enable || s.write_in_progress) ? PH_DROP : PH_RX;
			end else begin
				next_s.nbits = 7'h00;
				next_s.cmd   = 8'h00;
				next_s.ph    = PH_RX;
			end
		end else if (cs_rise) begin
			next_s.ph    = PH_IDLE;
			next_s.dq_oe = 1'b0;
			if (s.nbits == NB_CMD && s.cmd == OP_WR_ENABLE && !s.write_in_progress) begin
				next_s.write_enable_latch = 1'b1;
			end
			if (s.nbits == NB_BURST && s.cmd == OP_SET_BURST && !s.write_in_progress) begin
				if (s.sh[7:4] == WRAP_OFF_NIB) begin
					next_s.wrap_en = 1'b0;
				end else if (s.sh[7:0] <= WRAP_MAX_CODE) begin
					next_s.wrap_en = 1'b1;
					next_s.depth   = s.sh[1:0];
				end
			end
			// Exact bit count gives the byte-boundary check
			if (s.nbits == NB_ERASE && is_erase(s.cmd) && s.write_enable_latch && !s.write_in_progress
			    && !is_prot(s.sh[23:0], i_protect_mode_select,
			                i_block_protect_bits, i_sector_protect_bits)) begin
				next_s.write_in_progress      = 1'b1;
				next_s.er_start = 1'b1;
				unique case (s.cmd)
					OP_SECTOR_ERASE: begin
						next_s.er_kind = ER_SECTOR;
						next_s.er_addr = s.sh[23:0] & ~SECTOR_MASK;
						next_s.tmr     = 32'(SE_CYC - 1);
					end
					OP_HALF_BLOCK_ERASE: begin
						next_s.er_kind = ER_HALF_BLOCK;
						next_s.er_addr = s.sh[23:0] & ~HALF_BLOCK_MASK;
						next_s.tmr     = 32'(HB_CYC - 1);
					end
					default: begin
						next_s.er_kind = ER_BLOCK;
						next_s.er_addr = s.sh[23:0] & ~BLOCK_MASK;
						next_s.tmr     = 32'(BE_CYC - 1);
					end
				endcase
			end
			// All-ones address cycles in continuous mode drop the mode
			if (s.cont && s.nbits < NB_MODE && s.all_ones) begin
				next_s.cont = 1'b0;
			end
		end else if (rise) begin
			unique case (s.ph)
				PH_RX: begin
					next_s.sh       = rx_sh;
					next_s.nbits    = rx_nb;
					next_s.all_ones = s.all_ones & rx_ones;
					if (rx_nb == NB_CMD) begin
						next_s.cmd = rx_sh[7:0];
						if (rx_sh[7:0] == OP_QUAD_IO_READ && (!i_quad_enable || s.write_in_progress)) begin
							next_s.ph = PH_DROP;
						end
					end
					if (rx_nb == NB_MODE && s.cmd == OP_QUAD_IO_READ) begin
						next_s.addr = rx_sh[31:8];
						next_s.cont = rx_sh[7:4] == ~rx_sh[3:0];
						next_s.dcnt = 4'h0;
						next_s.ph   = PH_DUMMY;
					end
				end
				PH_DUMMY: begin
					next_s.dcnt = s.dcnt + 4'h1;
					if (s.dcnt == 4'(DUMMY - 1)) begin
						next_s.ph = PH_DATA;
						next_s.hi = 1'b1;
					end
				end
				PH_IDLE, PH_DATA, PH_DROP: begin
				end
			endcase
		end else if (fall && s.ph == PH_DATA) begin
			next_s.dq_oe = 1'b1;
			next_s.hi    = ~s.hi;
			if (s.hi) begin
				next_s.obyte = i_rd_data;
				next_s.dq_o  = i_rd_data[7:4];
			end else begin
				next_s.dq_o = s.obyte[3:0];
				next_s.addr = step_addr(s.addr, s.wrap_en, s.depth);
			end
		end
	end

	// Reset clears the wrap setting with all other state except the select history
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s      <= '0;
			// Select idles high; its history starts high so no false edge follows
			s.cs_s <= 2'b11;
			s.cs_q <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign link.dev_dq          = s.dq_o;
	assign link.dev_oe          = s.dq_oe ? 4'hF : 4'h0;
	assign o_rd_addr            = s.addr;
	assign o_write_in_progress  = s.write_in_progress;
	assign o_write_enable_latch = s.write_enable_latch;
	assign o_wrap_enable        = s.wrap_en;
	assign o_wrap_depth         = s.depth;
	assign o_cont_read          = s.cont;
	assign o_erase_start        = s.er_start;
	assign o_erase_kind         = s.er_kind;
	assign o_erase_addr         = s.er_addr;
endmodule

// ==== hw/sfw_host.sv ====
// Controller end: AXI4-Lite registers in, framed flash commands out.
// Assumes the flash answers on the pulled-up four-lane link.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module sfw_host #(
	parameter int unsigned HALF = sfw_pkg::SCLK_HALF_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	sfw_link_if.host         link,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready
);
	import sfw_pkg::*;

	typedef enum logic [3:0] {H_IDLE, H_SETUP, H_CMD, H_ADDR, H_ARG, H_MODE,
	                          H_DUMMY, H_DATA, H_END, H_GAP} sfw_hph_t;
	typedef struct packed {
		logic [31:0] tx;
		logic [8:0]  cnt;
		logic        wide;
		logic        drive;
	} sfw_hld_t;
	typedef struct packed {
		logic        aw_have;
		logic [7:0]  awaddr;
		logic        w_have;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] ctrl;
		logic [31:0] addr;
		logic [31:0] arg;
		sfw_hph_t    ph;
		logic [7:0]  div;
		logic        sclk;
		logic        cs_n;
		sfw_hld_t    ld;
		logic [3:0]  dq_s0;
		logic [3:0]  dq_s1;
		logic [7:0]  rx;
		logic [7:0]  last;
	} sfw_host_st_t;

	sfw_host_st_t s;
	sfw_host_st_t next_s;

	// ==========================================================
	// Frame building
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
	                                      input logic [3:0] b);
		for (int i = 0; i < 4; i++) begin
			if (b[i]) begin
				o[8*i +: 8] = d[8*i +: 8];
			end
		end
		return o;
	endfunction

	function automatic sfw_hph_t nxt(input sfw_hph_t p, input logic [7:0] op,
	                                 input logic [7:0] len);
		case (p)
			H_CMD:   return (op == OP_WR_ENABLE || op == OP_MODE_EXIT) ? H_END
			                : (op == OP_SET_BURST ? H_ARG : H_ADDR);
			H_ADDR:  return op == OP_QUAD_IO_READ ? H_MODE : H_END;
			H_MODE:  return H_DUMMY;
			H_DUMMY: return len == 8'h00 ? H_END : H_DATA;
			default: return H_END;
		endcase
	endfunction

	function automatic sfw_hld_t load(input sfw_hph_t p, input logic [31:0] c,
	                                  input logic [31:0] a, input logic [31:0] g);
		sfw_hld_t r;
		r = '0;
		r.drive = 1'b1;
		r.wide  = c[CTRL_QUAD_BIT];
		case (p)
			H_CMD: begin
				// Exit pattern is eight all-ones clocks on every lane
				r.tx  = c[7:0] == OP_MODE_EXIT ? 32'hFFFF_FFFF : {c[7:0], 24'h00_0000};
				r.cnt = (r.wide && c[7:0] != OP_MODE_EXIT) ? 9'h002 : 9'h008;
			end
			H_ADDR: begin
				r.wide = r.wide | c[CTRL_SKIP_BIT] | c[7:0] == OP_QUAD_IO_READ;
				r.tx   = {a[23:0], 8'h00};
				r.cnt  = r.wide ? 9'h006 : 9'h018;
			end
			H_ARG: begin
				r.tx  = {g[7:0], 24'h00_0000};
				r.cnt = r.wide ? 9'h002 : 9'h008;
			end
			H_MODE: begin
				r.wide = 1'b1;
				r.tx   = {g[7:0], 24'h00_0000};
				r.cnt  = 9'h002;
			end
			H_DUMMY: begin
				r.drive = 1'b0;
				r.cnt   = 9'(DUMMY_CLKS);
			end
			H_DATA: begin
				r.drive = 1'b0;
				r.cnt   = {g[15:8], 1'b0};
			end
			default: begin
				r.drive = 1'b0;
			end
		endcase
		return r;
	endfunction

	logic     tick;
	logic     do_wr;
	logic     busy;
	sfw_hph_t first;

	assign tick  = s.div == 8'(HALF - 1);
	assign busy  = s.ph != H_IDLE;
	assign do_wr = s.aw_have && s.w_have && !s.bvalid;
	assign first = s.ctrl[CTRL_SKIP_BIT] ? H_ADDR : H_CMD;

	// ==========================================================
	// Next state
	always_comb begin
		next_s       = s;
		next_s.dq_s0 = link.dq;
		next_s.dq_s1 = s.dq_s0;
		if (i_awvalid && o_awready) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr  = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			next_s.w_have = 1'b1;
			next_s.wdata  = i_wdata;
			next_s.wstrb  = i_wstrb;
		end
		if (s.bvalid && i_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && i_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (i_arvalid && o_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			unique case (i_araddr)
				REG_CTRL:   next_s.rdata = {21'h00_0000, s.ctrl[10:9], 1'b0, s.ctrl[7:0]};
				REG_ADDR:   next_s.rdata = {8'h00, s.addr[23:0]};
				REG_ARG:    next_s.rdata = {16'h0000, s.arg[15:0]};
				REG_STATUS: next_s.rdata = {31'h0000_0000, busy};
				REG_RDATA:  next_s.rdata = {24'h00_0000, s.last};
				default: begin
					next_s.rdata = 32'h0000_0000;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (do_wr) begin
			next_s.aw_have = 1'b0;
			next_s.w_have  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = RESP_OKAY;
			// Registers are frozen while a frame is on the link
			if (busy || !(s.awaddr == REG_CTRL || s.awaddr == REG_ADDR || s.awaddr == REG_ARG)) begin
				next_s.bresp = RESP_SLVERR;
			end else if (s.awaddr == REG_CTRL) begin
				next_s.ctrl = merge(s.ctrl, s.wdata, s.wstrb);
				next_s.ctrl[CTRL_GO_BIT] = 1'b0;
				if (s.wstrb[1] && s.wdata[CTRL_GO_BIT]) begin
					next_s.ph   = H_SETUP;
					next_s.cs_n = 1'b0;
					next_s.div  = 8'h00;
				end
			end else if (s.awaddr == REG_ADDR) begin
				next_s.addr = merge(s.addr, s.wdata, s.wstrb);
			end else begin
				next_s.arg = merge(s.arg, s.wdata, s.wstrb);
			end
		end
		if (busy) begin
			next_s.div = tick ? 8'h00 : s.div + 8'h01;
			if (tick) begin
				unique case (s.ph)
					H_SETUP: begin
						next_s.ph = first;
						next_s.ld = load(first, s.ctrl, s.addr, s.arg);
					end
					H_END: begin
						next_s.cs_n = 1'b1;
						next_s.ph   = H_GAP;
					end
					H_GAP: begin
						next_s.ph = H_IDLE;
					end
					H_IDLE, H_CMD, H_ADDR, H_ARG, H_MODE, H_DUMMY, H_DATA: begin
						next_s.sclk = ~s.sclk;
						if (!s.sclk) begin
							if (s.ph == H_DATA) begin
								next_s.rx = {s.rx[3:0], s.dq_s1};
							end
						end else begin
							next_s.ld.tx  = s.ld.wide ? {s.ld.tx[27:0], 4'hF} : {s.ld.tx[30:0], 1'b1};
							next_s.ld.cnt = s.ld.cnt - 9'h001;
							// Odd count at a fall: both nibbles of the byte are in
							if (s.ph == H_DATA && s.ld.cnt[0]) begin
								next_s.last = s.rx;
							end
							if (s.ld.cnt == 9'h001) begin
								next_s.ph = nxt(s.ph, s.ctrl[7:0], s.arg[15:8]);
								next_s.ld = load(nxt(s.ph, s.ctrl[7:0], s.arg[15:8]),
								                 s.ctrl, s.addr, s.arg);
							end
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s      <= '0;
			s.cs_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs; single-lane frames drive lane zero only
	assign link.cs_n    = s.cs_n;
	assign link.sclk    = s.sclk;
	assign link.host_dq = s.ld.wide ? s.ld.tx[31:28] : {3'b111, s.ld.tx[31]};
	assign link.host_oe = !s.ld.drive ? 4'h0 : (s.ld.wide ? 4'hF : 4'h1);
	assign o_awready    = !s.aw_have && !s.bvalid;
	assign o_wready     = !s.w_have && !s.bvalid;
	assign o_bvalid     = s.bvalid;
	assign o_bresp      = s.bresp;
	assign o_arready    = !s.rvalid;
	assign o_rvalid     = s.rvalid;
	assign o_rdata      = s.rdata;
	assign o_rresp      = s.rresp;
endmodule

// ==== dv/sfw_chk.sv ====
// Checker for erase status and mode flags seen beside the flash link.
// Assumes one clock domain and the asynchronous high reset of both ends.
`timescale 1ns/1ps
module sfw_chk (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic cs_n,
	input wire logic o_write_in_progress,
	input wire logic o_write_enable_latch,
	input wire logic o_erase_start,
	input wire logic o_wrap_enable,
	input wire logic o_cont_read
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	AST_RST_OFF: assert property ($past(i_rst) |-> !o_wrap_enable && !o_cont_read)
		else $error("mode flag set out of reset");
	AST_WRAP_HOLD: assert property ($changed(o_wrap_enable) |-> cs_n)
		else $error("wrap setting moved inside a frame");
	AST_START_CS: assert property (o_erase_start |-> cs_n)
		else $error("erase began with select low");
	AST_START_WEL: assert property (o_erase_start |-> o_write_enable_latch)
		else $error("erase began without write latch");
	AST_START_IDLE: assert property (o_erase_start |-> !$past(o_write_in_progress))
		else $error("erase began while busy");
	AST_PULSE: assert property (o_erase_start |=> !o_erase_start && o_write_in_progress)
		else $error("erase start not a pulse into busy");
	AST_WIP_CAUSE: assert property ($rose(o_write_in_progress) |-> o_erase_start || $past(o_erase_start))
		else $error("busy rose with no erase");
	AST_WEL_CLR: assert property ($fell(o_write_in_progress) |-> !o_write_enable_latch)
		else $error("write latch kept after erase");
	cover property (o_erase_start);
	cover property ($rose(o_wrap_enable));
	cover property ($rose(o_cont_read));
endmodule

// ==== dv/serial_flash_wrap_enhance_erase_tb.sv ====
// Bench joining controller and flash ends; drives the controller over AXI4-Lite.
// Assumes short erase counts so the run stays brief.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module serial_flash_wrap_enhance_erase_tb;
	import sfw_pkg::*;
	logic            clk = 0;
	logic            rst = 1;
	logic [7:0]      awaddr = 0, araddr = 0;
	logic [31:0]     wdata = 0;
	logic            awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic            awready, wready, bvalid, arready, rvalid;
	logic [1:0]      bresp, rresp, last_resp;
	logic [31:0]     rdata, d;
	logic            qm = 0, qe = 1, pms = 0;
	logic [3:0]      bp = 0;
	logic [15:0]     sector_protect_bits = 0;
	logic [23:0]     rd_addr, ea, st_addr;
	logic            write_in_progress, write_enable_latch, wen, cont, es;
	logic [1:0]      depth;
	sfw_erase_t      ek, st_kind;
	logic [7:0]      ops [3] = '{OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE};
	logic [23:0]     masks [3] = '{SECTOR_MASK, HALF_BLOCK_MASK, BLOCK_MASK};
	int              st_cnt = 0, n = 0, bad_count = 0, comparisons = 0;
	sfw_link_if link();
	always #2.5 clk = ~clk;
	sfw_host #(.HALF(8)) u_sfw_host (.i_ref_clk(clk), .i_rst(rst), .link(link),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready));
	// Array byte equals its low address bits, so wrap points are visible
	sfw_dev #(.SE_CYC(20), .HB_CYC(30), .BE_CYC(40)) u_sfw_dev (.i_ref_clk(clk),
		.i_rst(rst), .link(link), .i_quad_cmd_mode(qm), .i_quad_enable(qe),
		.i_protect_mode_select(pms), .i_block_protect_bits(bp),
		.i_sector_protect_bits(sector_protect_bits), .i_rd_data(rd_addr[7:0]), .o_rd_addr(rd_addr),
		.o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch), .o_wrap_enable(wen),
		.o_wrap_depth(depth), .o_cont_read(cont), .o_erase_start(es),
		.o_erase_kind(ek), .o_erase_addr(ea));
	sfw_chk u_sfw_chk (.i_ref_clk(clk), .i_rst(rst), .cs_n(link.cs_n),
		.o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch), .o_erase_start(es),
		.o_wrap_enable(wen), .o_cont_read(cont));
	always @(posedge clk) begin
		if (es) begin
			st_cnt <= st_cnt + 1;
			st_addr <= ea;
			st_kind <= ek;
		end
	end
	// ==========================================================
	// Bus tasks; each channel is judged at the rising edge that moves it
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic tb;
		tb = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!tb) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			tb = bvalid;
			last_resp = bresp;
		end
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic tr;
		tr = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!tr) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			tr = rvalid;
			d = rdata;
			last_resp = rresp;
		end
		rready <= 0;
	endtask
	task automatic frame(input logic [7:0] op, input logic q, input logic s,
		input logic [23:0] a, input logic [15:0] g);
		wr(REG_ADDR, {8'h00, a});
		wr(REG_ARG, {16'h0000, g});
		wr(REG_CTRL, {21'h0, s, q, 1'b1, op});
		d = 1;
		while (d[0]) rd(REG_STATUS);
		repeat (8) @(posedge clk);
	endtask
	task automatic er(input logic [7:0] op, input logic [23:0] a);
		frame(OP_WR_ENABLE, 0, 0, 0, 0);
		frame(op, 0, 0, a, 0);
		for (int k = 0; k < 200 && write_in_progress; k++) @(posedge clk);
	endtask
	task automatic final_report;
		$display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		`CHK({wen, cont}, 2'b00)
		wr(8'h20, 0);
		`CHK(last_resp, RESP_SLVERR)
		rd(8'h20);
		`CHK(last_resp, RESP_SLVERR)
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			qm <= i[0];
			frame(OP_SET_BURST, i[0], 0, 0, 16'(i));
			`CHK({wen, depth}, {1'b1, i[1:0]})
			frame(OP_QUAD_IO_READ, i[0], 0, 24'((8 << i) - 2), 16'h0400);
			rd(REG_RDATA);
			`CHK(d[7:0], 8'h01)
		end
		qm <= 0;
		frame(OP_SET_BURST, 0, 0, 0, 16'h001C);
		`CHK(wen, 1'b0)
		frame(OP_QUAD_IO_READ, 0, 0, 24'h00_0006, 16'h0400);
		rd(REG_RDATA);
		`CHK(d[7:0], 8'h09)
		$display("test burst done");
		qe <= 0;
		frame(OP_QUAD_IO_READ, 0, 0, 24'h00_0010, 16'h01A5);
		`CHK(cont, 1'b0)
		qe <= 1;
		frame(OP_QUAD_IO_READ, 0, 0, 24'h00_0010, 16'h01A5);
		`CHK(cont, 1'b1)
		frame(OP_QUAD_IO_READ, 0, 1, 24'h00_0020, 16'h015A);
		rd(REG_RDATA);
		`CHK({cont, d[7:0]}, 9'h120)
		frame(OP_QUAD_IO_READ, 0, 1, 24'h00_0030, 16'h0100);
		frame(OP_WR_ENABLE, 0, 0, 0, 0);
		`CHK({cont, write_enable_latch}, 2'b01)
		frame(OP_QUAD_IO_READ, 0, 0, 24'h00_0010, 16'h01A5);
		`CHK(cont, 1'b1)
		frame(OP_MODE_EXIT, 0, 0, 0, 0);
		`CHK(cont, 1'b0)
		$display("test continuous done");
		for (int i = 0; i < 3; i++) begin
			n = st_cnt;
			er(ops[i], 24'h12_3456);
			`CHK(st_cnt, n + 1)
			`CHK(st_addr, 24'h12_3456 & ~masks[i])
			`CHK(st_kind, sfw_erase_t'(i))
			`CHK({write_in_progress, write_enable_latch}, 2'b00)
		end
		n = st_cnt;
		frame(OP_SECTOR_ERASE, 0, 0, 24'h00_1000, 0);
		`CHK(st_cnt, n)
		// Quad frame that skips the opcode: erase code plus two address bytes only
		qm <= 1;
		frame(OP_WR_ENABLE, 1, 0, 0, 0);
		frame(OP_SECTOR_ERASE, 1, 1, 24'h20_1234, 0);
		`CHK({st_cnt, write_enable_latch}, {n, 1'b1})
		qm <= 0;
		$display("test erase done");
		bp <= 4'h1;
		er(OP_SECTOR_ERASE, 24'hF0_0000);
		`CHK(st_cnt, n)
		pms <= 1;
		bp <= 4'h0;
		sector_protect_bits <= 16'h0004;
		er(OP_BLOCK_ERASE, 24'h20_0000);
		`CHK(st_cnt, n)
		er(OP_SECTOR_ERASE, 24'h30_0000);
		`CHK(st_cnt, n + 1)
		$display("test protect done");
		final_report;
	end
	initial begin
		#300_000;
		bad_count++;
		final_report;
	end
endmodule
